// File: core/gpc_consts.vh
// Constants for the pin function configuration block.
// Assumes register indices are word indices on APB (byte address = 4 * index).
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

// Register indices (byte address is four times the index)
`define GPC_IDX_P37      10'h03a
`define GPC_IDX_P40      10'h03b
`define GPC_IDX_P41      10'h03c
`define GPC_IDX_P42      10'h03d
`define GPC_IDX_P43      10'h03e
`define GPC_IDX_P50      10'h03f
`define GPC_IDX_P51      10'h040
`define GPC_IDX_P52      10'h041
`define GPC_ADDR_LSB     2

// Pin slots in the pin vectors
`define GPC_PIN_37       0
`define GPC_PIN_40       1
`define GPC_PIN_41       2
`define GPC_PIN_42       3
`define GPC_PIN_43       4
`define GPC_PIN_50       5
`define GPC_PIN_51       6
`define GPC_PIN_52       7
`define GPC_NPINS        8

// Field positions
`define GPC_BIT_DIR      0
`define GPC_BIT_INV      1
`define GPC_BIT_SEL      2
`define GPC_BIT_SELHI    3
`define GPC_BIT_OD       7

// Reset value, writable masks and select clear mask
`define GPC_RST_CFG      8'h01
`define GPC_MASK_SEL1    8'h87
`define GPC_MASK_SEL2    8'h8f
`define GPC_SEL_CLR      8'hf3

// Two-bit select codes
`define GPC_SEL_GPIO     2'b00
`define GPC_SEL_C1       2'b01
`define GPC_SEL_C2       2'b10
`define GPC_SEL_C3       2'b11

`endif

// File: core/gpc_sync.v
// Two-flop synchroniser for asynchronous levels.
// Assumes inputs come from outside the pclk domain.
`timescale 1ns/10ps
module gpc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      q      <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // gpc_sync

// File: core/gpc_pin_cell.v
// One configurable pin: input sampling, polarity, direction, driver type.
// Assumes pin_in is asynchronous; pin_oe_n low means the pin is driven.
`timescale 1ns/10ps
module gpc_pin_cell (
  input  wire clk,
  input  wire rst_n,
  input  wire dir_in,
  input  wire invert,
  input  wire open_drain,
  input  wire src_value,
  input  wire pin_in,
  output reg  pin_out,
  output reg  pin_oe_n,
  output reg  level
);
  reg  meta_q;
  reg  sync_q;
  wire drv_val;

  assign drv_val = src_value ^ invert;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_q   <= 1'b0;
      level    <= 1'b0;
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      meta_q   <= pin_in;
      sync_q   <= meta_q;
      level    <= sync_q ^ invert;                           // [RULE2]
      pin_out  <= drv_val;
      // Open drain releases the pin for a high value
      pin_oe_n <= dir_in | (open_drain & drv_val);          // [RULE1] [RULE3]
    end
  end
endmodule // gpc_pin_cell

// File: core/gpc_pin_function_config.v
// Summary of operation
// [RULE1] Bit 0 one is input, zero output
// [RULE2] Bit 1 inverts pin value
// [RULE3] Bit 7 selects open drain over push-pull
// [RULE4] Pin 3.7 bit 2 selects gate A20
// [RULE5] Pin 4.0 bit 2 selects density select 0
// [RULE6] Pin 4.1 codes: interrupt 2, density 1
// [RULE7] Pin 4.2 bit 2 selects power event
// [RULE8] Power event drives active low when uninverted
// [RULE9] Pin 4.3 codes: interrupt 3, disable lock
// [RULE10] Lock mode forces 4.3 uninverted input
// [RULE11] Lock code ignores writes until reset
// [RULE12] Three resets clear 4.3 select field
// [RULE13] Pin 4.3 high makes disable register read-only
// [RULE14] Pin 5.0 code 01 is ring indicator
// [RULE15] Pin 5.1 code 01 is carrier detect
// [RULE16] Pin 5.2 code 01 is receive data
// [RULE17] Reserved bits 6:3 or 6:4
// [RULE18] Standby reset loads 0x01
// [RULE19] Reserved bits and codes read zero
//
// Eight pin configuration registers behind an APB slave.
// Assumes presetn is the standby-power reset; the other resets arrive as async levels.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`include "gpc_consts.vh"
module gpc_pin_function_config (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        main_power_reset,
  input  wire        hard_reset,
  input  wire [7:0]  port_pin_in,
  output wire [7:0]  port_pin_out,
  output wire [7:0]  port_pin_oe_n,
  input  wire [7:0]  gpio_data_out,
  output wire [7:0]  gpio_data_in,
  input  wire        gate_a20_function,
  input  wire        drive_density_sel_0,
  input  wire        drive_density_sel_1,
  input  wire        power_mgmt_event,
  output reg         edge_int_2_pulse,
  output reg         edge_int_3_pulse,
  output reg         device_disable_lock_control,
  output reg         device_disable_read_only,
  output reg         serial2_ring_indicator_n,
  output reg         serial2_carrier_detect_n,
  output reg         serial2_receive_data
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  function is_two_bit;
    input [2:0] slot;
    begin
      is_two_bit = (slot == `GPC_PIN_41) || (slot >= `GPC_PIN_43);
    end
  endfunction

  function code_reserved;
    input [2:0] slot;
    input [1:0] code;
    begin
      case (slot)
        `GPC_PIN_41: code_reserved = (code == `GPC_SEL_C3);        // [RULE6]
        `GPC_PIN_43: code_reserved = (code == `GPC_SEL_C2);        // [RULE9]
        `GPC_PIN_50,
        `GPC_PIN_51,
        `GPC_PIN_52: code_reserved = code[1];                      // [RULE14] [RULE15] [RULE16]
        default:     code_reserved = 1'b0;
      endcase
    end
  endfunction

  // Next register value after a software write
  function [7:0] cfg_write;
    input [2:0] slot;
    input [7:0] old;
    input [7:0] wdata;
    reg   [7:0] v;
    begin
      v = wdata & (is_two_bit(slot) ? `GPC_MASK_SEL2 : `GPC_MASK_SEL1); // [RULE17] [RULE19]
      if (is_two_bit(slot) && code_reserved(slot, v[3:2]))
        v = v & `GPC_SEL_CLR;                                       // [RULE19]
      if ((slot == `GPC_PIN_43) && (old[3:2] == `GPC_SEL_C1))
        v[3:2] = `GPC_SEL_C1;                                       // [RULE11]
      cfg_write = v;
    end
  endfunction

  function [2:0] addr_slot;
    input [9:0] idx;
    begin
      addr_slot = idx[2:0] - 3'd2;
    end
  endfunction

  // Two-bit select field of one register
  function [1:0] sel_code;
    input [7:0] cfg;
    begin
      sel_code = cfg[`GPC_BIT_SELHI:`GPC_BIT_SEL];
    end
  endfunction

  // Select bit of a register with one alternate function
  function sel_bit;
    input [7:0] cfg;
    begin
      sel_bit = cfg[`GPC_BIT_SEL];
    end
  endfunction

  // ==========================================================
  // Register storage and reset requests
  // ==========================================================
  reg  [7:0] cfg_q [0:`GPC_NPINS-1];
  wire [1:0] rst_req;
  wire       rst_clr;
  wire [9:0] word_idx;
  wire       aligned;
  wire       in_range;
  wire       hit;
  wire [2:0] slot;
  wire       setup_ph;
  wire       access_ph;
  wire       rd_setup;
  wire       wr_en;
  wire [7:0] wr_byte;
  wire [7:0] wr_next;
  wire [7:0] level;
  integer    k;

  gpc_sync #(
    .WIDTH (2)
  ) u_rst_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({hard_reset, main_power_reset}),
    .q     (rst_req)
  );

  // Either main-power or hard reset, already in the pclk domain
  assign rst_clr = |rst_req;

  // ==========================================================
  // APB address decode
  // ==========================================================
  assign word_idx  = paddr[11:`GPC_ADDR_LSB];
  assign aligned   = (paddr[`GPC_ADDR_LSB-1:0] == {`GPC_ADDR_LSB{1'h0}});
  assign in_range  = (word_idx >= `GPC_IDX_P37) && (word_idx <= `GPC_IDX_P52);
  assign hit       = aligned & in_range;
  assign slot      = addr_slot(word_idx);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & pready;
  assign rd_setup  = setup_ph & ~pwrite & hit;

  // Write strobe: end of the access cycle of a mapped write
  assign wr_byte   = pwdata[7:0];
  assign wr_en     = access_ph & pwrite & hit & pstrb[0];
  assign wr_next   = cfg_write(slot, cfg_q[slot], wr_byte);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < `GPC_NPINS; k = k + 1)
        cfg_q[k] <= `GPC_RST_CFG;                                   // [RULE18] [RULE12]
    end else begin
      if (wr_en)
        cfg_q[slot] <= wr_next;
      // Main-power or hard reset clears the 4.3 select, after any write
      if (rst_clr)
        cfg_q[`GPC_PIN_43] <= (wr_en && slot == `GPC_PIN_43) ?
          (wr_next & `GPC_SEL_CLR) :
          (cfg_q[`GPC_PIN_43] & `GPC_SEL_CLR);                      // [RULE12] [RULE11]
    end
  end

  // ==========================================================
  // APB slave: zero wait states, error on unmapped address
  // ==========================================================
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (rd_setup)
      rd_byte = cfg_q[slot];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit;
    end
  end

  // Read data stands only in the access cycle, zero otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= {24'h00_0000, rd_byte};
  end

  // ==========================================================
  // Alternate function selects
  // ==========================================================
  wire a20_en;
  wire den0_en;
  wire den1_en;
  wire pme_en;
  wire int2_en;
  wire int3_en;
  wire lock_sel;
  wire ring_en;
  wire dcd_en;
  wire rxd_en;

  // Reserved codes are never stored, so only real codes decode
  assign a20_en   = sel_bit(cfg_q[`GPC_PIN_37]);                   // [RULE4]
  assign den0_en  = sel_bit(cfg_q[`GPC_PIN_40]);                   // [RULE5]
  assign den1_en  = (sel_code(cfg_q[`GPC_PIN_41]) == `GPC_SEL_C1); // [RULE6]
  assign int2_en  = (sel_code(cfg_q[`GPC_PIN_41]) == `GPC_SEL_C2); // [RULE6]
  assign pme_en   = sel_bit(cfg_q[`GPC_PIN_42]);                   // [RULE7]
  assign int3_en  = (sel_code(cfg_q[`GPC_PIN_43]) == `GPC_SEL_C3); // [RULE9]
  assign lock_sel = (sel_code(cfg_q[`GPC_PIN_43]) == `GPC_SEL_C1); // [RULE9]
  assign ring_en  = (sel_code(cfg_q[`GPC_PIN_50]) == `GPC_SEL_C1); // [RULE14]
  assign dcd_en   = (sel_code(cfg_q[`GPC_PIN_51]) == `GPC_SEL_C1); // [RULE15]
  assign rxd_en   = (sel_code(cfg_q[`GPC_PIN_52]) == `GPC_SEL_C1); // [RULE16]

  // ==========================================================
  // Function routing per pin
  // ==========================================================
  reg [7:0] src;
  reg [7:0] dir_in;
  reg [7:0] inv;
  reg [7:0] od;
  integer   j;

  always @* begin
    // Plain GPIO by default; selected output functions replace the source
    for (j = 0; j < `GPC_NPINS; j = j + 1) begin
      src[j]    = gpio_data_out[j];
      dir_in[j] = cfg_q[j][`GPC_BIT_DIR];                          // [RULE1]
      inv[j]    = cfg_q[j][`GPC_BIT_INV];                          // [RULE2]
      od[j]     = cfg_q[j][`GPC_BIT_OD];                           // [RULE3]
    end
    if (a20_en)
      src[`GPC_PIN_37] = gate_a20_function;                        // [RULE4]
    if (den0_en)
      src[`GPC_PIN_40] = drive_density_sel_0;                      // [RULE5]
    if (den1_en)
      src[`GPC_PIN_41] = drive_density_sel_1;                      // [RULE6]
    // Event is active high inside; uninverted pin shows it low
    if (pme_en)
      src[`GPC_PIN_42] = ~power_mgmt_event;                        // [RULE7] [RULE8]
    if (lock_sel) begin
      dir_in[`GPC_PIN_43] = 1'h1;                                  // [RULE10]
      inv[`GPC_PIN_43]    = 1'h0;                                  // [RULE10]
    end
  end

  // Pin slots follow the register order
  genvar g;
  generate
    for (g = 0; g < `GPC_NPINS; g = g + 1) begin : g_pin
      gpc_pin_cell u_cell (
        .clk        (pclk),
        .rst_n      (presetn),
        .dir_in     (dir_in[g]),
        .invert     (inv[g]),
        .open_drain (od[g]),
        .src_value  (src[g]),
        .pin_in     (port_pin_in[g]),
        .pin_out    (port_pin_out[g]),
        .pin_oe_n   (port_pin_oe_n[g]),
        .level      (level[g])
      );
    end
  endgenerate

  assign gpio_data_in = level;

  // ==========================================================
  // Edge interrupts on pins 4.1 and 4.3
  // ==========================================================
  reg  [1:0] prev_q;
  wire [1:0] edge_lvl;
  wire [1:0] edge_seen;

  assign edge_lvl  = {level[`GPC_PIN_43], level[`GPC_PIN_41]};
  assign edge_seen = edge_lvl ^ prev_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q           <= 2'h0;
      edge_int_2_pulse <= 1'h0;
      edge_int_3_pulse <= 1'h0;
    end else begin
      prev_q           <= edge_lvl;
      edge_int_2_pulse <= int2_en & edge_seen[0];                  // [RULE6]
      edge_int_3_pulse <= int3_en & edge_seen[1];                  // [RULE9]
    end
  end

  // ==========================================================
  // Device-disable lock outputs
  // ==========================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_disable_lock_control <= 1'h0;
      device_disable_read_only    <= 1'h0;
    end else begin
      device_disable_lock_control <= lock_sel;                     // [RULE9]
      // Lock forces the pin uninverted, so level is the raw pin
      device_disable_read_only    <= lock_sel & level[`GPC_PIN_43]; // [RULE13]
    end
  end

  // ==========================================================
  // Second serial port inputs, idle high when not selected
  // ==========================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial2_ring_indicator_n <= 1'h1;
      serial2_carrier_detect_n <= 1'h1;
      serial2_receive_data     <= 1'h1;
    end else begin
      serial2_ring_indicator_n <= ring_en ? level[`GPC_PIN_50] : 1'h1; // [RULE14]
      serial2_carrier_detect_n <= dcd_en ? level[`GPC_PIN_51] : 1'h1;  // [RULE15]
      serial2_receive_data     <= rxd_en ? level[`GPC_PIN_52] : 1'h1;  // [RULE16]
    end
  end

endmodule // gpc_pin_function_config

// File: bench/gpc_props.sv
// Checker for the pin function configuration block.
// Assumes it sees only the ports of gpc_pin_function_config.
`timescale 1ns/10ps
module gpc_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        main_power_reset,
  input wire        hard_reset,
  input wire [7:0]  port_pin_oe_n,
  input wire        edge_int_2_pulse,
  input wire        edge_int_3_pulse,
  input wire        device_disable_lock_control,
  input wire        device_disable_read_only
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rst_any = main_power_reset | hard_reset;
  // ==========
  // Properties
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_apb_answer; s_setup |=> s_answer; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no single answer");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_rst_idle; $rose(presetn) |-> port_pin_oe_n == 8'hff && !device_disable_lock_control; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins driven after reset");
  property p_lock_in; device_disable_lock_control |-> port_pin_oe_n[4]; endproperty
  a_lock_in: assert property (p_lock_in) else $error("locked pin driven");
  property p_ro_lock; device_disable_read_only |-> device_disable_lock_control; endproperty
  a_ro_lock: assert property (p_ro_lock) else $error("read only without lock");
  property p_lock_hold; (!rst_any)[*5] ##0 device_disable_lock_control |=> device_disable_lock_control; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
  property p_lock_clear; rst_any[*5] |=> !device_disable_lock_control; endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept in reset");
  property p_int2; edge_int_2_pulse |=> !edge_int_2_pulse; endproperty
  a_int2: assert property (p_int2) else $error("pulse 2 too long");
  property p_int3; edge_int_3_pulse |=> !edge_int_3_pulse; endproperty
  a_int3: assert property (p_int3) else $error("pulse 3 too long");
endmodule // gpc_props
bind gpc_pin_function_config gpc_props i_gpc_props (.*);

// File: bench/tb_gpc_pin_function_config.sv
// Self-checking bench for the pin function configuration block.
// Assumes the checker file is compiled with it and binds itself.
`timescale 1ns/10ps
`include "gpc_consts.vh"
`define CK(a,b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected %0t got %h exp %h", $time, a, b); end end
module tb_gpc_pin_function_config;
  reg         pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  reg  [11:0] paddr = 12'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [3:0]  pstrb = 4'hf;
  reg         main_power_reset = 1'h0, hard_reset = 1'h0, gate_a20_function = 1'h0;
  reg         drive_density_sel_0 = 1'h0, drive_density_sel_1 = 1'h0, power_mgmt_event = 1'h0;
  reg  [7:0]  port_pin_in = 8'h0, gpio_data_out = 8'h0;
  wire [31:0] prdata;
  wire [7:0]  port_pin_out, port_pin_oe_n, gpio_data_in;
  wire        pready, pslverr, edge_int_2_pulse, edge_int_3_pulse, device_disable_lock_control;
  wire        device_disable_read_only, serial2_ring_indicator_n, serial2_carrier_detect_n;
  wire        serial2_receive_data;
  int         err_count = 0, samples_checked = 0, cyc = 0;
  reg  [31:0] rd;
  reg         er;
  gpc_pin_function_config i_gpc_pin_function_config (.*);
  initial forever #2 pclk = ~pclk;
  // ==========
  // Bus and helpers
  task apb(input [9:0] i, input w, input [7:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; paddr <= {i, 2'h0}; pwrite <= w; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task chk(input [9:0] i, input [7:0] e);
    apb(i, 1'h0, 8'h0);
    `CK(rd, {24'h0, e})
  endtask
  task st(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task pw(input s);
    int n;
    for (n = 0; n < 10 && (s ? edge_int_3_pulse : edge_int_2_pulse) !== 1'h1; n++) st(1);
    `CK(s ? edge_int_3_pulse : edge_int_2_pulse, 1'h1)
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Scenarios
  task t_reset;
    for (int k = 0; k < 8; k++) chk(`GPC_IDX_P37 + 10'(k), 8'h01);
    `CK(port_pin_oe_n, 8'hff)
    $display("t_reset done");
  endtask
  task t_gpio;
    @(posedge pclk) gpio_data_out <= 8'h01;
    apb(`GPC_IDX_P37, 1'h1, 8'h00); st(2);
    `CK(port_pin_oe_n[0], 1'h0)
    `CK(port_pin_out[0], 1'h1)
    apb(`GPC_IDX_P37, 1'h1, 8'h82); st(2);
    `CK(port_pin_oe_n[0], 1'h0)
    @(posedge pclk) gpio_data_out <= 8'h00; st(2);
    `CK(port_pin_oe_n[0], 1'h1)
    apb(`GPC_IDX_P37, 1'h1, 8'h03);
    @(posedge pclk) port_pin_in <= 8'h01; st(5);
    `CK(gpio_data_in[0], 1'h0)
    `CK(port_pin_oe_n[0], 1'h1)
    $display("t_gpio done");
  endtask
  task t_alt;
    @(posedge pclk);
    {gate_a20_function, drive_density_sel_0, drive_density_sel_1, power_mgmt_event} <= 4'hf;
    for (int k = 0; k < 4; k++) apb(`GPC_IDX_P37 + 10'(k), 1'h1, 8'h04);
    st(2);
    `CK(port_pin_out[0], 1'h1)
    `CK(port_pin_out[1], 1'h1)
    `CK(port_pin_out[2], 1'h1)
    `CK(port_pin_out[3], 1'h0)
    `CK(port_pin_oe_n[3:0], 4'h0)
    @(posedge pclk) power_mgmt_event <= 1'h0; st(2);
    `CK(port_pin_out[3], 1'h1)
    $display("t_alt done");
  endtask
  task t_edge;
    apb(`GPC_IDX_P41, 1'h1, 8'h09);
    apb(`GPC_IDX_P43, 1'h1, 8'h0d);
    @(posedge pclk) port_pin_in <= 8'h04;
    pw(1'h0);
    @(posedge pclk) port_pin_in <= 8'h14;
    pw(1'h1);
    $display("t_edge done");
  endtask
  task t_serial;
    for (int k = 0; k < 3; k++) apb(`GPC_IDX_P50 + 10'(k), 1'h1, 8'h05);
    @(posedge pclk) port_pin_in <= 8'h40; st(6);
    `CK(serial2_ring_indicator_n, 1'h0)
    `CK(serial2_carrier_detect_n, 1'h1)
    `CK(serial2_receive_data, 1'h0)
    @(posedge pclk) port_pin_in <= 8'ha0; st(6);
    `CK({serial2_ring_indicator_n, serial2_carrier_detect_n, serial2_receive_data}, 3'h5)
    $display("t_serial done");
  endtask
  task t_resv;
    apb(`GPC_IDX_P37, 1'h1, 8'hff);
    chk(`GPC_IDX_P37, 8'h87);
    apb(`GPC_IDX_P41, 1'h1, 8'hf1);
    chk(`GPC_IDX_P41, 8'h81);
    apb(`GPC_IDX_P50, 1'h1, 8'h0d);
    chk(`GPC_IDX_P50, 8'h01);
    apb(10'h042, 1'h0, 8'h00);
    `CK({er, rd}, 33'h100000000)
    $display("t_resv done");
  endtask
  task t_lock;
    apb(`GPC_IDX_P43, 1'h1, 8'h06);
    @(posedge pclk) port_pin_in <= 8'h10; st(6);
    `CK(device_disable_lock_control, 1'h1)
    `CK(port_pin_oe_n[4], 1'h1)
    `CK(device_disable_read_only, 1'h1)
    @(posedge pclk) port_pin_in <= 8'h00; st(6);
    `CK(device_disable_read_only, 1'h0)
    apb(`GPC_IDX_P43, 1'h1, 8'h00);
    chk(`GPC_IDX_P43, 8'h04);
    @(posedge pclk) main_power_reset <= 1'h1; st(6);
    @(posedge pclk) main_power_reset <= 1'h0; st(4);
    chk(`GPC_IDX_P43, 8'h00);
    apb(`GPC_IDX_P43, 1'h1, 8'h05);
    @(posedge pclk) hard_reset <= 1'h1; st(6);
    @(posedge pclk) hard_reset <= 1'h0; st(4);
    chk(`GPC_IDX_P43, 8'h01);
    `CK(device_disable_lock_control, 1'h0)
    $display("t_lock done");
  endtask
  task t_standby;
    @(posedge pclk) presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    chk(`GPC_IDX_P37, 8'h01);
    chk(`GPC_IDX_P41, 8'h01);
    `CK(port_pin_oe_n, 8'hff)
    $display("t_standby done");
  endtask
  // ==========
  // Sequence and timeout
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_gpio;
    t_alt;
    t_edge;
    t_serial;
    t_resv;
    t_lock;
    t_standby;
    test_done;
  end
endmodule // tb_gpc_pin_function_config
